// ---- core/gpo_port.sv ----
// Eight-bit general-purpose port with pull-up and open-drain control
`timescale 1ns/1ps

module gpo_port #(
	parameter int unsigned WIDTH = 8
) (
	// Clock and reset
	input  wire logic                          sys_clk_i,
	input  wire logic                          rst_n_i,
	// Register port
	input  wire logic [gpo_pkg::ADDR_W-1:0]    addr_i,
	input  wire logic [gpo_pkg::DATA_W-1:0]    wdata_i,
	input  wire logic                          wr_i,
	input  wire logic                          rd_i,
	input  wire logic                          bit_acc_i,
	input  wire logic [gpo_pkg::BSEL_W-1:0]    bit_sel_i,
	output logic      [gpo_pkg::DATA_W-1:0]    rdata_o,
	// Alternate function sources
	input  wire logic [WIDTH-1:0]              rt_out_i,
	input  wire logic [WIDTH-1:0]              ext_addr_i,
	// Pins
	input  wire logic [WIDTH-1:0]              pin_in_i,
	output logic      [WIDTH-1:0]              pin_out_o,
	output logic      [WIDTH-1:0]              pin_oe_o,
	output logic      [WIDTH-1:0]              pin_pullup_o
);

	// ==================================================================
	// Helpers

	// Bit access replaces one bit, byte access the whole byte
	function automatic logic [7:0] merge_wr(
		input logic [7:0]                   old_v,
		input logic [7:0]                   new_v,
		input logic                         bit_acc,
		input logic [gpo_pkg::BSEL_W-1:0]   sel
	);
		logic [7:0] mask;
		mask = bit_acc ? (8'h01 << sel) : 8'hff;
		return (old_v & ~mask) | (new_v & mask);
	endfunction

	// Bit read shows only the selected bit, others zero
	function automatic logic [7:0] mask_rd(
		input logic [7:0]                   val,
		input logic                         bit_acc,
		input logic [gpo_pkg::BSEL_W-1:0]   sel
	);
		logic [7:0] mask;
		mask = bit_acc ? (8'h01 << sel) : 8'hff;
		return val & mask;
	endfunction

	// ==================================================================
	// Registers
	logic [7:0]                  dir_ff;
	logic [7:0]                  pu_ff;
	logic [7:0]                  od_ff;
	logic [7:0]                  latch_ff;
	logic [7:0]                  amode_ff;
	logic [7:0]                  rtsel_ff;
	logic [gpo_pkg::DATA_W-1:0]  rdata_ff;

	logic [7:0]                  nxt_dir;
	logic [7:0]                  nxt_pu;
	logic [7:0]                  nxt_od;
	logic [7:0]                  nxt_latch;
	logic [7:0]                  nxt_amode;
	logic [7:0]                  nxt_rtsel;
	logic [gpo_pkg::DATA_W-1:0]  nxt_rdata;

	// ==================================================================
	// Address decode
	wire logic sel_dir;
	wire logic sel_pu;
	wire logic sel_od;
	wire logic sel_latch;
	wire logic sel_amode;
	wire logic sel_rtsel;
	wire logic [7:0] wbyte;

	assign sel_dir   = (addr_i == gpo_pkg::OFS_PIN_DIRECTION);
	assign sel_pu    = (addr_i == gpo_pkg::OFS_PULLUP_ENABLE);
	assign sel_od    = (addr_i == gpo_pkg::OFS_OPEN_DRAIN_SEL);
	assign sel_latch = (addr_i == gpo_pkg::OFS_PORT_DATA);
	assign sel_amode = (addr_i == gpo_pkg::OFS_ADDR_OUT_MODE);
	assign sel_rtsel = (addr_i == gpo_pkg::OFS_RT_OUT_SELECT);
	assign wbyte     = wdata_i[7:0];

	// ==================================================================
	// Next register values
	// Writes to unmapped addresses fall through and change nothing
	assign nxt_dir   = (wr_i && sel_dir)   ? merge_wr(dir_ff, wbyte, bit_acc_i, bit_sel_i)   : dir_ff;
	assign nxt_pu    = (wr_i && sel_pu)    ? merge_wr(pu_ff, wbyte, bit_acc_i, bit_sel_i)    : pu_ff;
	assign nxt_od    = (wr_i && sel_od)    ? merge_wr(od_ff, wbyte, bit_acc_i, bit_sel_i)    : od_ff;
	assign nxt_latch = (wr_i && sel_latch) ? merge_wr(latch_ff, wbyte, bit_acc_i, bit_sel_i) : latch_ff;
	assign nxt_amode = (wr_i && sel_amode) ? merge_wr(amode_ff, wbyte, bit_acc_i, bit_sel_i) : amode_ff;
	assign nxt_rtsel = (wr_i && sel_rtsel) ? merge_wr(rtsel_ff, wbyte, bit_acc_i, bit_sel_i) : rtsel_ff;

	// ==================================================================
	// Read path
	wire logic [7:0] latch_view;
	wire logic [7:0] rd_byte;
	wire logic       rd_hit;

	// Inputs show the pin, outputs show the latch
	assign latch_view = (pin_in_i & dir_ff) | (latch_ff & ~dir_ff);

	assign rd_byte = sel_dir   ? dir_ff     :
	                 sel_pu    ? pu_ff      :
	                 sel_od    ? od_ff      :
	                 sel_latch ? latch_view :
	                 sel_amode ? amode_ff   :
	                 sel_rtsel ? rtsel_ff   : 8'h00;
	assign rd_hit  = sel_dir | sel_pu | sel_od | sel_latch | sel_amode | sel_rtsel;

	// Data valid only in the cycle after the strobe
	assign nxt_rdata = !rd_i   ? gpo_pkg::RD_UNMAPPED :
	                   !rd_hit ? gpo_pkg::RD_UNMAPPED :
	                   {24'h000000, mask_rd(rd_byte, bit_acc_i, bit_sel_i)};

	// ==================================================================
	// Register update
	// Direction resets to all ones so every pin starts as input
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			dir_ff   <= gpo_pkg::RST_PIN_DIRECTION;
			pu_ff    <= gpo_pkg::RST_PULLUP_ENABLE;
			od_ff    <= gpo_pkg::RST_OPEN_DRAIN_SEL;
			latch_ff <= gpo_pkg::RST_PORT_DATA;
			amode_ff <= gpo_pkg::RST_ADDR_OUT_MODE;
			rtsel_ff <= gpo_pkg::RST_RT_OUT_SELECT;
			rdata_ff <= gpo_pkg::RD_UNMAPPED;
		end else begin
			dir_ff   <= nxt_dir;
			pu_ff    <= nxt_pu;
			od_ff    <= nxt_od;
			latch_ff <= nxt_latch;
			amode_ff <= nxt_amode;
			rtsel_ff <= nxt_rtsel;
			rdata_ff <= nxt_rdata;
		end
	end

	assign rdata_o = rdata_ff;

	// ==================================================================
	// Alternate function select
	// Address bits win over realtime bits when both are selected.
	// The alternate value reaches the pin only once software has
	// put that pin in output mode; nothing forces the direction.
	wire logic [WIDTH-1:0] alt_en;
	wire logic [WIDTH-1:0] alt_val;

	assign alt_en  = amode_ff | rtsel_ff;
	assign alt_val = (amode_ff & ext_addr_i) | (~amode_ff & rtsel_ff & rt_out_i);

	// ==================================================================
	// Pad cells
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_pin
			gpo_pin_cell i_gpo_pin_cell (
				.dir_in_i  (dir_ff[gi]),
				.od_sel_i  (od_ff[gi]),
				.pu_en_i   (pu_ff[gi]),
				.latch_i   (latch_ff[gi]),
				.alt_en_i  (alt_en[gi]),
				.alt_val_i (alt_val[gi]),
				.pad_out_o (pin_out_o[gi]),
				.pad_oe_o  (pin_oe_o[gi]),
				.pad_pu_o  (pin_pullup_o[gi])
			);
		end
	endgenerate

	// ==================================================================
	// Checks
	// Expected pin value rebuilt from the registers, not from the
	// merge wires, so a slip in the select logic shows up here
	wire logic [WIDTH-1:0] exp_addr_term;
	wire logic [WIDTH-1:0] exp_rt_term;
	wire logic [WIDTH-1:0] exp_drive;

	assign exp_addr_term = amode_ff & ext_addr_i;
	assign exp_rt_term   = ~amode_ff & rtsel_ff & rt_out_i;
	assign exp_drive     = latch_ff | exp_addr_term | exp_rt_term;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	// Byte write to the latch while all pins are push-pull outputs
	sequence s_latch_byte_wr;
		wr_i && sel_latch && !bit_acc_i && dir_ff == 8'h00 && od_ff == 8'h00 && alt_en == 8'h00;
	endsequence

	// Byte read of the latch
	sequence s_latch_rd;
		rd_i && sel_latch && !bit_acc_i;
	endsequence

	// First cycle after reset release: all pins input, nothing driven
	property p_reset_input;
		@(posedge sys_clk_i) disable iff (1'b0)
		(rst_n_i && $past(!rst_n_i)) |-> (pin_oe_o == 8'h00 && dir_ff == 8'hff);
	endproperty
	a_reset_input: assert property (p_reset_input) else $error("pins not input after reset");

	property p_latch_to_pin;
		s_latch_byte_wr ##1 (dir_ff == 8'h00 && od_ff == 8'h00 && alt_en == 8'h00)
		|-> (pin_out_o == $past(wdata_i[7:0]) && pin_oe_o == 8'hff);
	endproperty
	a_latch_to_pin: assert property (p_latch_to_pin) else $error("latch write not on pin");

	property p_read_mix;
		s_latch_rd |=> rdata_o[7:0] == (($past(pin_in_i) & $past(dir_ff)) | ($past(latch_ff) & ~$past(dir_ff)));
	endproperty
	a_read_mix: assert property (p_read_mix) else $error("latch read wrong mix");

	property p_pullup_follow;
		(wr_i && sel_pu && !bit_acc_i) |=> pin_pullup_o == $past(wdata_i[7:0]);
	endproperty
	a_pullup_follow: assert property (p_pullup_follow) else $error("pull-up not as written");

	// Open-drain never drives high, input pins never drive at all
	property p_no_high_od;
		((pin_out_o & od_ff) == 8'h00) && ((pin_oe_o & dir_ff) == 8'h00);
	endproperty
	a_no_high_od: assert property (p_no_high_od) else $error("illegal pad drive");

	// Push-pull output pins show latch ORed with alternate value
	property p_or_merge;
		((pin_out_o ^ exp_drive) & ~dir_ff & ~od_ff) == 8'h00;
	endproperty
	a_or_merge: assert property (p_or_merge) else $error("alternate merge wrong");

	// Open-drain output pins pull low exactly when the value is 0
	property p_od_low;
		((pin_oe_o ^ ~exp_drive) & ~dir_ff & od_ff) == 8'h00;
	endproperty
	a_od_low: assert property (p_od_low) else $error("open-drain enable wrong");

	// Bit write to direction touches only the selected bit
	property p_bit_write;
		(wr_i && sel_dir && bit_acc_i) |=>
		((dir_ff ^ $past(dir_ff)) & ~(8'h01 << $past(bit_sel_i))) == 8'h00 &&
		dir_ff[$past(bit_sel_i)] == $past(wdata_i[bit_sel_i]);
	endproperty
	a_bit_write: assert property (p_bit_write) else $error("bit write spilled");

	// Read data stand for one cycle only
	property p_rdata_once;
		!rd_i |=> rdata_o == 32'h00000000;
	endproperty
	a_rdata_once: assert property (p_rdata_once) else $error("read data held too long");

	// Address mode pins on push-pull output carry their address bit
	property p_addr_map;
		(amode_ff == 8'hff && dir_ff == 8'h00 && od_ff == 8'h00 && latch_ff == 8'h00)
		|-> pin_out_o == ext_addr_i;
	endproperty
	a_addr_map: assert property (p_addr_map) else $error("address bit mapping wrong");

	// Byte write to direction lands whole
	property p_dir_byte;
		(wr_i && sel_dir && !bit_acc_i) |=>
		dir_ff == $past(wbyte);
	endproperty
	a_dir_byte: assert property (p_dir_byte) else $error("direction byte write lost");

	// Byte write to open-drain select lands whole
	property p_od_byte;
		(wr_i && sel_od && !bit_acc_i) |=>
		od_ff == $past(wbyte);
	endproperty
	a_od_byte: assert property (p_od_byte) else $error("open-drain byte write lost");

	// Latch stores writes even while its pins are inputs
	property p_latch_byte;
		(wr_i && sel_latch && !bit_acc_i) |=>
		latch_ff == $past(wbyte);
	endproperty
	a_latch_byte: assert property (p_latch_byte) else $error("latch byte write lost");

	// Bit write to pull-up touches only the selected bit
	property p_pu_bit;
		(wr_i && sel_pu && bit_acc_i) |=>
		((pu_ff ^ $past(pu_ff)) & ~(8'h01 << $past(bit_sel_i))) == 8'h00 &&
		pu_ff[$past(bit_sel_i)] == $past(wbyte[bit_sel_i]);
	endproperty
	a_pu_bit: assert property (p_pu_bit) else $error("pull-up bit write spilled");

	// Bit read shows nothing but the selected bit
	property p_rd_bit;
		(rd_i && rd_hit && bit_acc_i) |=>
		(rdata_o[7:0] & ~(8'h01 << $past(bit_sel_i))) == 8'h00;
	endproperty
	a_rd_bit: assert property (p_rd_bit) else $error("bit read shows other bits");

	// Direction changes only on its own write
	property p_dir_hold;
		!(wr_i && sel_dir) |=>
		dir_ff == $past(dir_ff);
	endproperty
	a_dir_hold: assert property (p_dir_hold) else $error("direction changed unasked");

	// Pull-up changes only on its own write
	property p_pu_hold;
		!(wr_i && sel_pu) |=>
		pu_ff == $past(pu_ff);
	endproperty
	a_pu_hold: assert property (p_pu_hold) else $error("pull-up changed unasked");

	// Open-drain select changes only on its own write
	property p_od_hold;
		!(wr_i && sel_od) |=>
		od_ff == $past(od_ff);
	endproperty
	a_od_hold: assert property (p_od_hold) else $error("open-drain select changed unasked");

	// Latch changes only on its own write, never from the pins
	property p_latch_hold;
		!(wr_i && sel_latch) |=>
		latch_ff == $past(latch_ff);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch changed unasked");

	// Upper read lanes carry nothing on an eight-bit port
	property p_rdata_upper;
		rdata_o[31:8] == 24'h000000;
	endproperty
	a_rdata_upper: assert property (p_rdata_upper) else $error("upper read lanes not zero");

	// Unmapped reads return zero
	property p_unmapped_rd;
		(rd_i && !rd_hit) |=>
		rdata_o == gpo_pkg::RD_UNMAPPED;
	endproperty
	a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");

	// Realtime-only pins on push-pull output carry their realtime bit
	property p_rt_map;
		((pin_out_o ^ rt_out_i) & ~dir_ff & ~od_ff & ~amode_ff & rtsel_ff & ~latch_ff) == 8'h00;
	endproperty
	a_rt_map: assert property (p_rt_map) else $error("realtime bit mapping wrong");

endmodule

// ---- core/gpo_pkg.sv ----
// Constants for the 8-bit open-drain capable general-purpose port
//
// Functional notes
// - Per-bit direction; cleared bit means output mode
// - Output pins follow port data latch immediately
// - Latch read returns pin level for inputs
// - Latch read returns stored value for outputs
// - Per-pin pull-up, connected only when bit set
// - Per-pin push-pull or open-drain; cleared is push-pull
// - Reset returns every pin to input mode
// - Alternate output ORed with latch bit on pin
// - Control registers accept bit or byte access
// - Pin n carries realtime bit n or address n+5
package gpo_pkg;

	// ==================================================================
	// Widths
	localparam int unsigned ADDR_W   = 32;
	localparam int unsigned DATA_W   = 32;
	localparam int unsigned PORT_W   = 8;
	localparam int unsigned BSEL_W   = 3;

	// ==================================================================
	// Register byte addresses
	localparam logic [31:0] OFS_PIN_DIRECTION  = 32'hfffff034;
	localparam logic [31:0] OFS_PULLUP_ENABLE  = 32'hfffff094;
	localparam logic [31:0] OFS_OPEN_DRAIN_SEL = 32'hfffff0b4;
	localparam logic [31:0] OFS_PORT_DATA      = 32'hfffff014;
	localparam logic [31:0] OFS_ADDR_OUT_MODE  = 32'hfffff064;
	localparam logic [31:0] OFS_RT_OUT_SELECT  = 32'hfffff0d4;

	// ==================================================================
	// Values after reset
	localparam logic [7:0] RST_PIN_DIRECTION  = 8'hff;
	localparam logic [7:0] RST_PULLUP_ENABLE  = 8'h00;
	localparam logic [7:0] RST_OPEN_DRAIN_SEL = 8'h00;
	localparam logic [7:0] RST_PORT_DATA      = 8'h00;
	localparam logic [7:0] RST_ADDR_OUT_MODE  = 8'h00;
	localparam logic [7:0] RST_RT_OUT_SELECT  = 8'h00;

	// ==================================================================
	// Misc
	localparam logic [31:0] RD_UNMAPPED       = 32'h00000000;
	localparam int unsigned ADDR_BIT_BASE     = 5;

endpackage

// ---- core/gpo_pin_cell.sv ----
// One pad driver: push-pull or open-drain with alternate output merge
`timescale 1ns/1ps

module gpo_pin_cell (
	// Configuration
	input  wire logic dir_in_i,
	input  wire logic od_sel_i,
	input  wire logic pu_en_i,
	// Output sources
	input  wire logic latch_i,
	input  wire logic alt_en_i,
	input  wire logic alt_val_i,
	// Pad side
	output logic      pad_out_o,
	output logic      pad_oe_o,
	output logic      pad_pu_o
);

	// ==================================================================
	// Value merge
	wire logic alt_term;
	wire logic drive_val;
	wire logic out_mode;

	// Alternate output only counts while selected
	assign alt_term  = alt_en_i & alt_val_i;
	assign drive_val = latch_i | alt_term;
	assign out_mode  = ~dir_in_i;

	// ==================================================================
	// Pad drivers
	// Open-drain never drives high; the board or pull-up does that
	assign pad_out_o = od_sel_i ? 1'b0 : drive_val;
	assign pad_oe_o  = out_mode & (od_sel_i ? ~drive_val : 1'b1);
	assign pad_pu_o  = pu_en_i;

endmodule

// ---- verification/tb_top.sv ----
// Self-checking testbench for the eight-bit general-purpose port
`timescale 1ns/1ps

module tb_top;

	// ==========================================================
	// Stimulus and observation signals
	logic        sys_clk_i  = 1'b0;
	logic        rst_n_i    = 1'b0;
	logic [31:0] addr_i     = 32'h00000000;
	logic [31:0] wdata_i    = 32'h00000000;
	logic        wr_i       = 1'b0;
	logic        rd_i       = 1'b0;
	logic        bit_acc_i  = 1'b0;
	logic [2:0]  bit_sel_i  = 3'h0;
	logic [7:0]  rt_out_i   = 8'h00;
	logic [7:0]  ext_addr_i = 8'h00;
	logic [7:0]  pin_in_i   = 8'h00;
	logic [31:0] rdata_o;
	logic [7:0]  pin_out_o;
	logic [7:0]  pin_oe_o;
	logic [7:0]  pin_pullup_o;
	int          n_errors   = 0;
	int          n_tests    = 0;

	// 40 MHz system clock
	always #12.5 sys_clk_i = ~sys_clk_i;

	gpo_port #(.WIDTH(8)) i_gpo_port (
		.sys_clk_i    (sys_clk_i),
		.rst_n_i      (rst_n_i),
		.addr_i       (addr_i),
		.wdata_i      (wdata_i),
		.wr_i         (wr_i),
		.rd_i         (rd_i),
		.bit_acc_i    (bit_acc_i),
		.bit_sel_i    (bit_sel_i),
		.rdata_o      (rdata_o),
		.rt_out_i     (rt_out_i),
		.ext_addr_i   (ext_addr_i),
		.pin_in_i     (pin_in_i),
		.pin_out_o    (pin_out_o),
		.pin_oe_o     (pin_oe_o),
		.pin_pullup_o (pin_pullup_o)
	);

	// ==========================================================
	// Shared helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One-cycle write; pins are settled once the taking edge has passed
	task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic b = 1'b0, input logic [2:0] s = 3'h0);
		@(posedge sys_clk_i);
		wr_i      <= 1'b1;
		addr_i    <= a;
		wdata_i   <= {24'h000000, d};
		bit_acc_i <= b;
		bit_sel_i <= s;
		@(posedge sys_clk_i);
		wr_i      <= 1'b0;
		bit_acc_i <= 1'b0;
		#1;
	endtask

	// One-cycle read; data stand only in the following cycle
	task automatic rd(input logic [31:0] a, input logic [7:0] exp, input logic b = 1'b0, input logic [2:0] s = 3'h0);
		@(posedge sys_clk_i);
		rd_i      <= 1'b1;
		addr_i    <= a;
		bit_acc_i <= b;
		bit_sel_i <= s;
		@(posedge sys_clk_i);
		rd_i      <= 1'b0;
		bit_acc_i <= 1'b0;
		#1;
		chk(rdata_o, {24'h000000, exp});
	endtask

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		chk(pin_oe_o, 8'h00);
		chk(pin_pullup_o, 8'h00);
		rd(gpo_pkg::OFS_PIN_DIRECTION, 8'hff);
		rd(gpo_pkg::OFS_PULLUP_ENABLE, 8'h00);
		rd(gpo_pkg::OFS_OPEN_DRAIN_SEL, 8'h00);
		$display("t_reset done");
	endtask

	// Latch drives pins; mixed direction read mixes pins and latch
	task automatic t_output();
		wr(gpo_pkg::OFS_PORT_DATA, 8'ha5);
		chk(pin_oe_o, 8'h00);
		wr(gpo_pkg::OFS_PIN_DIRECTION, 8'h00);
		chk(pin_out_o, 8'ha5);
		chk(pin_oe_o, 8'hff);
		wr(gpo_pkg::OFS_PORT_DATA, 8'h3c);
		chk(pin_out_o, 8'h3c);
		wr(gpo_pkg::OFS_PORT_DATA, 8'ha5);
		@(posedge sys_clk_i);
		pin_in_i <= 8'h3c;
		rd(gpo_pkg::OFS_PORT_DATA, 8'ha5);
		wr(gpo_pkg::OFS_PIN_DIRECTION, 8'h0f);
		chk(pin_oe_o, 8'hf0);
		rd(gpo_pkg::OFS_PORT_DATA, 8'hac);
		$display("t_output done");
	endtask

	// Pull-up per pin, byte and bit access
	task automatic t_pullup();
		wr(gpo_pkg::OFS_PULLUP_ENABLE, 8'h5a);
		chk(pin_pullup_o, 8'h5a);
		rd(gpo_pkg::OFS_PULLUP_ENABLE, 8'h40, 1'b1, 3'h6);
		wr(gpo_pkg::OFS_PULLUP_ENABLE, 8'h01, 1'b1, 3'h0);
		chk(pin_pullup_o, 8'h5b);
		wr(gpo_pkg::OFS_PULLUP_ENABLE, 8'h00, 1'b1, 3'h6);
		chk(pin_pullup_o, 8'h1b);
		$display("t_pullup done");
	endtask

	// Open-drain pins only sink, and never while in input mode
	task automatic t_open_drain();
		wr(gpo_pkg::OFS_PIN_DIRECTION, 8'h00);
		wr(gpo_pkg::OFS_OPEN_DRAIN_SEL, 8'hf0);
		chk(pin_out_o & 8'hf0, 8'h00);
		chk(pin_oe_o, 8'h5f);
		rd(gpo_pkg::OFS_OPEN_DRAIN_SEL, 8'h80, 1'b1, 3'h7);
		wr(gpo_pkg::OFS_PIN_DIRECTION, 8'h80, 1'b1, 3'h7);
		chk(pin_oe_o, 8'h5f);
		wr(gpo_pkg::OFS_PIN_DIRECTION, 8'h00, 1'b1, 3'h7);
		wr(gpo_pkg::OFS_PIN_DIRECTION, 8'h40, 1'b1, 3'h6);
		chk(pin_oe_o, 8'h1f);
		rd(gpo_pkg::OFS_PIN_DIRECTION, 8'h40, 1'b1, 3'h6);
		wr(gpo_pkg::OFS_OPEN_DRAIN_SEL, 8'h00);
		wr(gpo_pkg::OFS_PIN_DIRECTION, 8'h00);
		chk(pin_out_o, 8'ha5);
		$display("t_open_drain done");
	endtask

	// Address bits ORed with the latch, realtime bits over a clear latch
	task automatic t_alternate();
		wr(gpo_pkg::OFS_PORT_DATA, 8'h10);
		@(posedge sys_clk_i);
		ext_addr_i <= 8'hc3;
		rt_out_i   <= 8'h5a;
		wr(gpo_pkg::OFS_ADDR_OUT_MODE, 8'hff);
		chk(pin_out_o, 8'hd3);
		wr(gpo_pkg::OFS_PORT_DATA, 8'h00);
		chk(pin_out_o, 8'hc3);
		wr(gpo_pkg::OFS_RT_OUT_SELECT, 8'hff);
		wr(gpo_pkg::OFS_ADDR_OUT_MODE, 8'h0f);
		chk(pin_out_o, 8'h53);
		wr(gpo_pkg::OFS_PIN_DIRECTION, 8'hf0);
		chk(pin_oe_o, 8'h0f);
		wr(gpo_pkg::OFS_ADDR_OUT_MODE, 8'h00);
		@(posedge sys_clk_i);
		rt_out_i <= 8'h81;
		#1;
		chk(pin_out_o & 8'h0f, 8'h01);
		$display("t_alternate done");
	endtask

	// Unmapped place reads zero and ignores writes
	task automatic t_unmapped();
		wr(32'hfffff000, 8'hff);
		rd(32'hfffff000, 8'h00);
		rd(gpo_pkg::OFS_PIN_DIRECTION, 8'hf0);
		$display("t_unmapped done");
	endtask

	// Reset in mid-run puts every pin back to input mode
	task automatic t_rerst();
		@(posedge sys_clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		@(posedge sys_clk_i);
		#1;
		chk(pin_oe_o, 8'h00);
		chk(pin_out_o, 8'h00);
		rd(gpo_pkg::OFS_PIN_DIRECTION, 8'hff);
		$display("t_rerst done");
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (10) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		@(posedge sys_clk_i);
		#1;
		t_reset();
		t_output();
		t_pullup();
		t_open_drain();
		t_alternate();
		t_unmapped();
		t_rerst();
		end_sim();
	end

endmodule
